// file: verilog/multi_channel_correction_select.sv
// multi-channel correction select: channel choice, slot lookup, storage
// assumes scanner pins asynchronous, measuring engine on i_clk
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module multi_channel_correction_select
    import mcc_pkg::*;
(
    // clock, reset, freeze
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    // avalon-mm slave
    input  wire logic [7:0]  i_avm_address,
    input  wire logic        i_avm_read,
    input  wire logic        i_avm_write,
    input  wire logic [31:0] i_avm_writedata,
    input  wire logic [3:0]  i_avm_byteenable,
    output logic      [31:0] o_avm_readdata,
    output logic             o_avm_waitrequest,
    // scanner pins
    input  wire logic [7:0]  i_channel_select_bits_n,
    input  wire logic        i_channel_select_qualifier_n,
    input  wire logic        i_external_measure_trigger,
    // measuring engine
    input  wire logic        i_raw_valid,
    input  wire logic [31:0] i_raw_a,
    input  wire logic [31:0] i_raw_b,
    input  wire logic [30:0] i_meas_freq,
    output logic             o_meas_start,
    // result toward the correction arithmetic
    output logic             o_res_valid,
    output logic [31:0]      o_res_a,
    output logic [31:0]      o_res_b,
    output logic [1:0]       o_res_slot,
    output logic             o_apply_open,
    output logic             o_apply_short,
    output logic             o_apply_load,
    output logic [3:0]       o_reference_parameter_function,
    output logic [6:0]       o_cur_channel
);
    mcc_state_s s;
    mcc_state_s next_s;

    logic                   mem_we;
    logic                   mem_re;
    logic [`MCC_MEM_AW-1:0] mem_addr;
    logic [31:0]            mem_wd;
    logic [31:0]            mem_rd;
    logic                   trig_edge;
    logic                   cmd_go;
    logic                   chan_wr;
    logic                   bus_req;
    logic [`MCC_CH_W-1:0]   ch;
    logic [3:0]             item_a;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] w,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = w[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // correction store

    corr_mem #(
        .AW (`MCC_MEM_AW),
        .DW (32)
    ) u_mem (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (mem_we),
        .i_re    (mem_re),
        .i_addr  (mem_addr),
        .i_wdata (mem_wd),
        .o_rdata (mem_rd)
    );

    ////////////////////////////////////////////////////////////////////
    // next-state logic

    // single mode always works on the set of channel 0
    assign ch        = s.multi ? s.chan : `MCC_CHAN_RST;
    assign trig_edge = s.trg2 & ~s.trg3;
    assign bus_req   = i_avm_read | i_avm_write;
    assign item_a    = `MCC_ITEM_OPEN_A - 4'h2 + {1'b0, s.ckind, 1'b0};

    always_comb begin
        logic [31:0] w;
        w        = 32'h0000_0000;
        next_s   = s;
        mem_we   = 1'b0;
        mem_re   = 1'b0;
        mem_addr = {ch, s.ptr};
        mem_wd   = i_avm_writedata;
        cmd_go   = 1'b0;
        chan_wr  = 1'b0;
        next_s.res_valid = 1'b0;
        next_s.ms        = 1'b0;

        // pin synchronisers; select lines are read at stage two, the trigger edge at stages two and three
        next_s.pin1 = {i_channel_select_qualifier_n,
                       i_channel_select_bits_n};
        next_s.pin2 = s.pin1;
        next_s.trg1 = i_external_measure_trigger;
        next_s.trg2 = s.trg1;
        next_s.trg3 = s.trg2;

        // a raw result is held until the sequencer takes it
        if (i_raw_valid) begin
            next_s.raw_pend = 1'b1;
            next_s.raw_a    = i_raw_a;
            next_s.raw_b    = i_raw_b;
            next_s.raw_f    = i_meas_freq;
        end

        // bus: one wait cycle (two for a data-word read), write lands when waitrequest is low
        if (s.ack) begin
            next_s.ack = 1'b0;
            if (i_avm_write) begin
                unique case (i_avm_address)
                    `MCC_OFS_CTRL: begin
                        // merge into the live control bits, not readdata
                        w = merge({20'h0, s.reference_parameter_function, 3'h0, s.load_en,
                                   s.short_en, s.open_en, s.multi,
                                   s.scan_on},
                                  i_avm_writedata, i_avm_byteenable);
                        next_s.scan_on  = w[`MCC_CTRL_SCAN];
                        next_s.multi    = w[`MCC_CTRL_MULTI] &
                                          w[`MCC_CTRL_SCAN];
                        next_s.open_en  = w[`MCC_CTRL_OPEN];
                        next_s.short_en = w[`MCC_CTRL_SHORT];
                        next_s.load_en  = w[`MCC_CTRL_LOAD];
                        next_s.reference_parameter_function     = w[`MCC_CTRL_REFERENCE_PARAMETER_FUNCTION +: 4];
                    end
                    `MCC_OFS_CHAN: begin
                        if (i_avm_byteenable[0]) begin
                            chan_wr     = 1'b1;
                            next_s.chan = i_avm_writedata[6:0];
                        end
                    end
                    `MCC_OFS_PTR: begin
                        w = merge({26'h0, s.ptr}, i_avm_writedata,
                                  i_avm_byteenable);
                        next_s.ptr = w[5:0];
                    end
                    `MCC_OFS_DATA: begin
                        mem_we = 1'b1;
                    end
                    `MCC_OFS_CMD: begin
                        if (s.st == ST_IDLE &&
                            i_avm_writedata[1:0] != 2'h0 &&
                            i_avm_writedata[5:4] < `MCC_SLOTS) begin
                            cmd_go       = 1'b1;
                            next_s.ckind = i_avm_writedata[1:0];
                            next_s.cslot = i_avm_writedata[5:4];
                            next_s.st    = ST_CWAIT;
                            next_s.ms    = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (bus_req && i_avm_address == `MCC_OFS_DATA) begin
            // memory word needs the idle sequencer
            if (s.st == ST_IDLE && i_avm_write) begin
                next_s.ack = 1'b1;
            end else if (s.st == ST_IDLE) begin
                mem_re    = 1'b1;
                next_s.st = ST_BRD;
            end
        end else if (bus_req) begin
            next_s.ack = 1'b1;
            unique case (i_avm_address)
                `MCC_OFS_CTRL:   next_s.rdata = {20'h0, s.reference_parameter_function, 3'h0,
                    s.load_en, s.short_en, s.open_en, s.multi, s.scan_on};
                `MCC_OFS_CHAN:   next_s.rdata = {25'h0, ch};
                `MCC_OFS_PTR:    next_s.rdata = {26'h0, s.ptr};
                `MCC_OFS_CMD:    next_s.rdata = {26'h0, s.cslot, 2'h0,
                                                 s.ckind};
                `MCC_OFS_STATUS: next_s.rdata = {27'h0, s.multi, s.slot,
                                                 s.hit, s.st != ST_IDLE};
                default:         next_s.rdata = 32'h0000_0000;
            endcase
        end

        // scanner code taken only at trigger or correction start
        if (trig_edge || cmd_go) begin
            // line 7 high means code bit 7 clear, so the code fits 0..127
            if (!s.pin2[8] && s.multi && s.pin2[7]) begin
                next_s.chan = ~s.pin2[6:0];
            end
        end
        if (trig_edge) begin
            next_s.ms = 1'b1;
        end

        // sequencer
        unique case (s.st)
            ST_IDLE: begin
                // a pending data-word access or command owns the port
                if (s.raw_pend && !mem_we && !mem_re && !cmd_go &&
                    !(bus_req && i_avm_address == `MCC_OFS_DATA)) begin
                    next_s.raw_pend = 1'b0;
                    next_s.idx      = 2'h0;
                    next_s.hit      = 1'b0;
                    next_s.st       = ST_LOOK;
                end
            end
            ST_BRD: begin
                next_s.rdata = mem_rd;
                next_s.ack   = 1'b1;
                next_s.st    = ST_IDLE;
            end
            ST_LOOK: begin
                // read slot idx while checking slot idx-1
                mem_addr = {ch, s.idx, `MCC_ITEM_FREQ};
                mem_re   = s.idx != `MCC_SLOTS;
                if (s.idx != 2'h0 && !s.hit &&
                    mem_rd[`MCC_FREQ_EN] && mem_rd[30:0] == s.raw_f) begin
                    next_s.hit  = 1'b1;
                    next_s.slot = s.idx - 2'h1;
                end
                next_s.idx = s.idx + 2'h1;
                if (s.idx == `MCC_SLOTS) begin
                    next_s.st        = ST_IDLE;
                    next_s.res_valid = 1'b1;
                    next_s.res_a     = s.raw_a;
                    next_s.res_b     = s.raw_b;
                    // no hit: raw value goes out uncorrected
                    next_s.ap_o = next_s.hit & s.open_en;
                    next_s.ap_s = next_s.hit & s.short_en;
                    next_s.ap_l = next_s.hit & s.load_en;
                end
            end
            ST_CWAIT: begin
                if (s.raw_pend) begin
                    mem_we          = 1'b1;
                    mem_addr        = {ch, s.cslot, item_a};
                    mem_wd          = s.raw_a;
                    next_s.raw_pend = 1'b0;
                    next_s.st       = ST_CWRB;
                end
            end
            ST_CWRB: begin
                mem_we    = 1'b1;
                mem_addr  = {ch, s.cslot, item_a + 4'h1};
                mem_wd    = s.raw_b;
                next_s.st = ST_IDLE;
            end
            default: next_s.st = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register; i_ce low freezes everything

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s       <= '0;
            s.st    <= ST_IDLE;
            s.pin1  <= 9'h1FF;
            s.pin2  <= 9'h1FF;
            s.chan  <= `MCC_CHAN_RST;
            s.reference_parameter_function  <= `MCC_REFERENCE_PARAMETER_FUNCTION_RST;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    // outputs
    assign o_avm_waitrequest = bus_req & ~s.ack;
    assign o_avm_readdata    = s.rdata;
    assign o_meas_start      = s.ms;
    assign o_res_valid       = s.res_valid;
    assign o_res_a           = s.res_a;
    assign o_res_b           = s.res_b;
    assign o_res_slot        = s.slot;
    assign o_apply_open      = s.ap_o;
    assign o_apply_short     = s.ap_s;
    assign o_apply_load      = s.ap_l;
    assign o_reference_parameter_function = s.reference_parameter_function;
    assign o_cur_channel     = ch;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_two_writes;
        mem_we ##1 mem_we;
    endsequence

    property p_code_taken;
        (trig_edge && i_ce && !s.pin2[8] && s.multi && s.pin2[7])
            |=> s.chan == ~$past(s.pin2[6:0]);
    endproperty
    a_code_taken: assert property (p_code_taken)
        else $error("scanner code not taken as channel");

    property p_qual_high;
        (trig_edge && s.pin2[8] && !chan_wr) |=> $stable(s.chan);
    endproperty
    a_qual_high: assert property (p_qual_high)
        else $error("channel changed with qualifier high");

    property p_only_sampled;
        $changed(s.chan) |-> $past((trig_edge | cmd_go | chan_wr) & i_ce);
    endproperty
    a_only_sampled: assert property (p_only_sampled)
        else $error("channel changed outside sampling point");

    property p_host_now;
        (chan_wr && i_ce && !trig_edge)
            |=> s.chan == $past(i_avm_writedata[6:0]);
    endproperty
    a_host_now: assert property (p_host_now)
        else $error("host channel not applied next cycle");

    property p_raw_out;
        (o_res_valid && !s.hit)
            |-> !(o_apply_open || o_apply_short || o_apply_load);
    endproperty
    a_raw_out: assert property (p_raw_out)
        else $error("correction applied without frequency match");

    property p_enables;
        o_res_valid |-> (!o_apply_open || s.open_en) &&
                        (!o_apply_short || s.short_en) &&
                        (!o_apply_load || s.load_en);
    endproperty
    a_enables: assert property (p_enables)
        else $error("correction applied while disabled");

    property p_store;
        (s.st == ST_CWAIT && s.raw_pend) |-> s_two_writes;
    endproperty
    a_store: assert property (p_store)
        else $error("correction result not stored as two words");

    property p_multi_gate;
        s.multi |-> s.scan_on;
    endproperty
    a_multi_gate: assert property (p_multi_gate)
        else $error("multi mode without scanner enabled");
endmodule : multi_channel_correction_select

// file: verilog/mcc_consts.svh
// offsets, field positions, reset values and item layout of the
// multi-channel correction select block; definitions only
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH

// geometry of the correction memory
`define MCC_CH_W        7
`define MCC_SLOT_W      2
`define MCC_ITEM_W      4
`define MCC_SLOTS       2'd3
`define MCC_MEM_AW      13
`define MCC_CH_MAX      7'h7F

// register byte offsets
`define MCC_OFS_CTRL    8'h00
`define MCC_OFS_CHAN    8'h04
`define MCC_OFS_PTR     8'h08
`define MCC_OFS_DATA    8'h0C
`define MCC_OFS_CMD     8'h10
`define MCC_OFS_STATUS  8'h14

// control register fields
`define MCC_CTRL_SCAN   0
`define MCC_CTRL_MULTI  1
`define MCC_CTRL_OPEN   2
`define MCC_CTRL_SHORT  3
`define MCC_CTRL_LOAD   4
`define MCC_CTRL_REFERENCE_PARAMETER_FUNCTION   8

// reset values
`define MCC_CHAN_RST    7'h00
`define MCC_REFERENCE_PARAMETER_FUNCTION_RST    4'h0

// word items inside one slot of one channel
`define MCC_ITEM_FREQ   4'h0
`define MCC_ITEM_REF_A  4'h1
`define MCC_ITEM_REF_B  4'h2
`define MCC_ITEM_OPEN_A 4'h3
`define MCC_FREQ_EN     31

`endif

// file: verilog/mcc_pkg.sv
// types of the multi-channel correction select block
// assumes mcc_consts.svh on the include path
package mcc_pkg;
    `include "mcc_consts.svh"

    typedef enum logic [2:0] {
        ST_IDLE, ST_BRD, ST_LOOK, ST_CWAIT, ST_CWRB
    } state_e;

    typedef struct packed {
        state_e                 st;
        logic                   ack;
        logic [31:0]            rdata;
        logic [8:0]             pin1;
        logic [8:0]             pin2;
        logic                   trg1;
        logic                   trg2;
        logic                   trg3;
        logic                   scan_on;
        logic                   multi;
        logic                   open_en;
        logic                   short_en;
        logic                   load_en;
        logic [3:0]             reference_parameter_function;
        logic [`MCC_CH_W-1:0]   chan;
        logic [5:0]             ptr;
        logic [1:0]             ckind;
        logic [1:0]             cslot;
        logic                   raw_pend;
        logic [31:0]            raw_a;
        logic [31:0]            raw_b;
        logic [30:0]            raw_f;
        logic [1:0]             idx;
        logic                   hit;
        logic [1:0]             slot;
        logic                   res_valid;
        logic                   ms;
        logic                   ap_o;
        logic                   ap_s;
        logic                   ap_l;
        logic [31:0]            res_a;
        logic [31:0]            res_b;
    } mcc_state_s;
endpackage : mcc_pkg

// file: verilog/corr_mem.sv
// single-port store for per-channel correction words
// assumes one user; read data registered, one cycle after the request
`timescale 1ns/1ps
module corr_mem #(
    parameter int AW = 13,
    parameter int DW = 32
) (
    // clock and freeze
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    // access port
    input  wire logic          i_we,
    input  wire logic          i_re,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array; contents are software's business
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end
            if (i_re) begin
                o_rdata <= mem[i_addr];
            end
        end
    end
endmodule : corr_mem

// file: sim/scanner_ctl_model.sv
// scanner controller model: drives channel code, qualifier, trigger
// assumes lines pulled up when not driven, trigger active high
`timescale 1ns/1ps
module scanner_ctl_model (
    // clock
    input  wire logic       i_clk,
    // commands from the bench
    input  wire logic [7:0] i_code,
    input  wire logic       i_present,
    input  wire logic       i_qual,
    input  wire logic       i_fire,
    // scanner lines
    output logic      [7:0] o_bits_n,
    output logic            o_qual_n,
    output logic            o_trig
);
    logic [2:0] hold_cnt;
    ////////////////////////////////////////////////////////////////////
    // released lines float to the pull-up level, never the last code
    initial begin
        o_bits_n = 8'hFF;
        o_qual_n = 1'b1;
        o_trig   = 1'b0;
        hold_cnt = 3'h0;
    end
    always @(posedge i_clk) begin
        o_bits_n <= i_present ? ~i_code : 8'hFF;
        o_qual_n <= ~(i_present & i_qual);
        // trigger held several cycles so a synchroniser cannot miss it
        if (i_fire)
            hold_cnt <= 3'h4;
        else if (hold_cnt != 3'h0)
            hold_cnt <= hold_cnt - 3'h1;
        o_trig <= (hold_cnt != 3'h0);
    end
endmodule : scanner_ctl_model

// file: sim/tb.sv
// self-checking bench of the multi-channel correction select block
// assumes the scanner model in scanner_ctl_model.sv, one 250 MHz clock
`timescale 1ns/1ps
module tb;
    import mcc_pkg::*;
    logic        i_clk, i_arst_n;
    logic [7:0]  av_addr, sc_code;
    logic        av_rd, av_wr, raw_v, sc_present, sc_qual, sc_fire;
    logic [31:0] av_wd, raw_a, raw_b, rdata, res_a, res_b, avm_rdata;
    logic [30:0] mfreq;
    logic [7:0]  bits_n;
    logic        qual_n, trig, waitreq, meas_start, res_v, ap_o, ap_s;
    logic        ap_l;
    logic [1:0]  res_slot;
    logic [3:0]  ref_reference_parameter_function;
    logic [6:0]  cur_ch;
    int          error_cnt, samples_checked, cyc;
    ////////////////////////////////////////////////////////////////////
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;
    multi_channel_correction_select dut_u (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
        .i_avm_address(av_addr), .i_avm_read(av_rd),
        .i_avm_write(av_wr), .i_avm_writedata(av_wd),
        .i_avm_byteenable(4'hF), .o_avm_readdata(avm_rdata),
        .o_avm_waitrequest(waitreq),
        .i_channel_select_bits_n(bits_n),
        .i_channel_select_qualifier_n(qual_n),
        .i_external_measure_trigger(trig), .i_raw_valid(raw_v),
        .i_raw_a(raw_a), .i_raw_b(raw_b), .i_meas_freq(mfreq),
        .o_meas_start(meas_start), .o_res_valid(res_v),
        .o_res_a(res_a), .o_res_b(res_b), .o_res_slot(res_slot),
        .o_apply_open(ap_o), .o_apply_short(ap_s), .o_apply_load(ap_l),
        .o_reference_parameter_function(ref_reference_parameter_function),
        .o_cur_channel(cur_ch));
    scanner_ctl_model scan_u (
        .i_clk(i_clk), .i_code(sc_code), .i_present(sc_present),
        .i_qual(sc_qual), .i_fire(sc_fire), .o_bits_n(bits_n),
        .o_qual_n(qual_n), .o_trig(trig));
    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        av_addr <= a;
        av_wd   <= d;
        av_wr   <= wr;
        av_rd   <= ~wr;
        do @(posedge i_clk); while (waitreq !== 1'b0);
        rdata = avm_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask : bus
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdata);
    endtask : rd_chk
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wait_cyc
    task automatic meas(input logic [30:0] f, input logic [31:0] a,
                        input logic [1:0] sl, input logic [2:0] ap);
        @(posedge i_clk);
        raw_v <= 1'b1;
        raw_a <= a;
        raw_b <= ~a;
        mfreq <= f;
        @(posedge i_clk);
        raw_v <= 1'b0;
        do @(negedge i_clk); while (res_v !== 1'b1);
        chk("res_a", a, res_a);
        chk("res_b", ~a, res_b);
        chk("apply", {29'h0, ap}, {29'h0, ap_o, ap_s, ap_l});
        if (ap != 3'h0) chk("slot", {30'h0, sl}, {30'h0, res_slot});
    endtask : meas
    ////////////////////////////////////////////////////////////////////
    task automatic t_ctrl;
        rd_chk("ctrl_rst", 8'h00, 32'h0);
        bus(1'b1, 8'h00, 32'h0000_0002);
        rd_chk("multi_no_scan", 8'h00, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        bus(1'b1, 8'h00, 32'h0000_031F);
        rd_chk("ctrl", 8'h00, 32'h0000_031F);
        chk("reference_parameter_function", 32'h3, {28'h0, ref_reference_parameter_function});
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_store;
        bus(1'b1, 8'h04, 32'd20);
        wait_cyc(1);
        chk("host_chan", 32'd20, {25'h0, cur_ch});
        bus(1'b1, 8'h08, 32'h00);
        bus(1'b1, 8'h0C, 32'h8000_03E8);
        bus(1'b1, 8'h08, 32'h01);
        bus(1'b1, 8'h0C, 32'h0000_1111);
        bus(1'b1, 8'h08, 32'h02);
        bus(1'b1, 8'h0C, 32'h0000_2222);
        bus(1'b1, 8'h08, 32'h10);
        bus(1'b1, 8'h0C, 32'h0000_07D0);
        bus(1'b1, 8'h08, 32'h20);
        bus(1'b1, 8'h0C, 32'h8000_07D0);
        bus(1'b1, 8'h04, 32'd127);
        rd_chk("chan_max", 8'h04, 32'd127);
        bus(1'b1, 8'h08, 32'h00);
        bus(1'b1, 8'h0C, 32'h8000_0BB8);
        bus(1'b1, 8'h04, 32'd20);
        rd_chk("freq_kept", 8'h0C, 32'h8000_03E8);
        bus(1'b1, 8'h08, 32'h01);
        rd_chk("ref_a", 8'h0C, 32'h0000_1111);
        bus(1'b1, 8'h08, 32'h02);
        rd_chk("ref_b", 8'h0C, 32'h0000_2222);
        $display("test store done");
    endtask : t_store
    task automatic t_meas;
        meas(31'd1000, 32'h1234_5678, 2'd0, 3'b111);
        meas(31'd2000, 32'hCAFE_0001, 2'd2, 3'b111);
        meas(31'd3000, 32'h0BAD_F00D, 2'd0, 3'b000);
        bus(1'b1, 8'h00, 32'h0000_0307);
        meas(31'd1000, 32'h5555_AAAA, 2'd0, 3'b100);
        bus(1'b1, 8'h00, 32'h0000_0313);
        meas(31'd2000, 32'h0000_0042, 2'd2, 3'b001);
        $display("test meas done");
    endtask : t_meas
    task automatic fire;
        @(posedge i_clk);
        sc_fire <= 1'b1;
        @(posedge i_clk);
        sc_fire <= 1'b0;
        wait_cyc(12);
    endtask : fire
    task automatic t_scan;
        sc_code    <= 8'd10;
        sc_present <= 1'b1;
        sc_qual    <= 1'b1;
        wait_cyc(12);
        chk("no_trig", 32'd20, {25'h0, cur_ch});
        fire();
        chk("trig_ch", 32'd10, {25'h0, cur_ch});
        sc_code <= 8'd127;
        sc_qual <= 1'b0;
        fire();
        chk("qual_off", 32'd10, {25'h0, cur_ch});
        sc_qual <= 1'b1;
        fire();
        chk("ch127", 32'd127, {25'h0, cur_ch});
        $display("test scan done");
    endtask : t_scan
    task automatic t_cmd;
        int n;
        logic seen;
        sc_code <= 8'd30;
        wait_cyc(4); // let the new code through the pin synchroniser
        bus(1'b1, 8'h10, 32'h0000_0001);
        n = 0;
        while (meas_start !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        chk("meas_start", 32'h1, {31'h0, meas_start});
        wait_cyc(2);
        chk("cmd_ch", 32'd30, {25'h0, cur_ch});
        // a correction result is stored, no corrected result goes out
        seen = 1'b0;
        @(posedge i_clk);
        raw_v <= 1'b1;
        raw_a <= 32'h0000_AAAA;
        raw_b <= 32'hFFFF_5555;
        mfreq <= 31'd5;
        @(posedge i_clk);
        raw_v <= 1'b0;
        repeat (8) begin
            @(negedge i_clk);
            if (res_v !== 1'b0) seen = 1'b1;
        end
        chk("cmd_no_res", 32'h0, {31'h0, seen});
        rd_chk("status", 8'h14, 32'h0000_001A);
        bus(1'b1, 8'h08, 32'h03);
        rd_chk("open_a", 8'h0C, 32'h0000_AAAA);
        bus(1'b1, 8'h08, 32'h04);
        rd_chk("open_b", 8'h0C, 32'hFFFF_5555);
        $display("test cmd done");
    endtask : t_cmd
    ////////////////////////////////////////////////////////////////////
    initial begin
        i_arst_n   = 1'b0;
        av_addr    = 8'h00;
        av_rd      = 1'b0;
        av_wr      = 1'b0;
        av_wd      = 32'h0;
        raw_v      = 1'b0;
        raw_a      = 32'h0;
        raw_b      = 32'h0;
        mfreq      = 31'h0;
        sc_code    = 8'h00;
        sc_present = 1'b0;
        sc_qual    = 1'b0;
        sc_fire    = 1'b0;
        error_cnt  = 0;
        samples_checked = 0;
        cyc        = 0;
        repeat (20) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_ctrl();
        t_store();
        t_meas();
        t_scan();
        t_cmd();
        conclude();
    end
endmodule : tb
